// file: stl_l1_monitor.sv
// Port checker for the layer-1 activation control
`timescale 1ns/1ps
module stl_l1_monitor
	import stl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [3:0] ciInd,
	input wire logic dataClockOe_n,
	input wire logic frameSyncOe_n,
	input wire logic txPos,
	input wire logic txNeg
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	wire logic rdReq = hsel && hready && htrans[1] && !hwrite;
	logic [3:0] indPrev;
	logic [15:0] indAge;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			indPrev <= IND_RES;
		else
			indPrev <= ciInd;
	end
	// Cycles since the indication last changed, saturating
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			indAge <= 16'h0;
		else if (ciInd != indPrev)
			indAge <= 16'h0;
		else if (indAge != 16'hffff)
			indAge <= indAge + 16'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	zero_wait_a: assert property (hreadyout == 1'b1)
		else $error("bus ready dropped");
	oe_pair_a: assert property (dataClockOe_n == frameSyncOe_n)
		else $error("clock and sync pin enables differ");
	ami_mark_a: assert property (!(txPos && txNeg))
		else $error("both mark polarities driven");
	ind_stands_a: assert property (ciInd != indPrev |-> indAge >= 16'h2ee0)
		else $error("indication changed within one frame");
	ind_read_a: assert property (rdReq && haddr == {24'h0, OFS_IND}
		|=> hrdata == {28'h0, $past(ciInd)})
		else $error("indication readback wrong");
	zero_read_a: assert property (rdReq && haddr == 32'h40
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	rd_hold_a: assert property (!rdReq |=> $stable(hrdata))
		else $error("read data moved without a read");
endmodule // stl_l1_monitor

bind stl_layer1_ctrl stl_l1_monitor mon (.mclk, .rst_n, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .ciInd,
	.dataClockOe_n, .frameSyncOe_n, .txPos, .txNeg);

// file: stl_layer1_ctrl.sv
// Layer-1 activation control: state machine, registers, bus clocks
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module stl_layer1_ctrl
	import stl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] ciCmd,
	output logic [3:0] ciInd,
	input wire logic [1:0] rxInfo,
	input wire logic rxSync,
	input wire logic rxLevel,
	input wire logic rxViolation,
	input wire logic rxData,
	input wire logic upstreamData,
	output logic downstreamData,
	output logic dataClockOut,
	output logic dataClockOe_n,
	output logic frameSyncOut,
	output logic frameSyncOe_n,
	output logic bitClock,
	output logic txPos,
	output logic txNeg,
	output logic loopTxData,
	output logic intLoopEn,
	output logic awakeDetEn,
	output logic irq
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	stl_state_e state_reg, state_next;
	logic [4:0] conf0_reg;
	logic txDis_reg, cfs_reg, spu_reg, prio10_reg, wake_reg;
	logic [2:0] swCmd_reg;
	logic [1:0] irqStat_reg, irqMask_reg;
	logic [3:0] rxStat_reg;
	logic violArm_reg, violShow_reg, levelPrev_reg, clkRun_reg;
	logic dataPh_reg, dataWr_reg;
	logic [7:0] dataAddr_reg;
	logic [31:0] rdNext;
	logic [3:0] indNext;
	logic addrPh, wrAcc, rdRxStat, swSel, trDis, extLp, loopOn, levelSeen;
	logic bitTick, dclTick, fscTick, cmdTake, rxChange, ldEvent;
	stl_tx_e txMode;

	assign swSel = conf0_reg[B_SWSEL];
	assign trDis = conf0_reg[B_TRDIS];
	assign extLp = conf0_reg[B_EXTLP];
	assign loopOn = (state_reg == ST_LOOP_CL) || (state_reg == ST_LOOP_ACT);
	assign levelSeen = rxLevel && !trDis;
	assign cmdTake = fscTick && !swSel && !trDis;

	// ----------------------------------------------------------------
	// Rate enables
	// ----------------------------------------------------------------
	stl_rate_gen #(.INC(BIT_INC)) u_bitRate (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(!trDis),
		.tick(bitTick)
	);
	stl_rate_gen #(.INC(DCL_INC)) u_dclRate (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(clkRun_reg),
		.tick(dclTick)
	);
	stl_rate_gen #(.INC(FSC_INC)) u_fscRate (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(clkRun_reg),
		.tick(fscTick)
	);

	// ----------------------------------------------------------------
	// Activation state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
				if (cmdTake && ciCmd == CMD_DI)
					state_next = ST_PDOWN;
			ST_PEND_DEACT:
				if (cmdTake && ciCmd == CMD_DI)
					state_next = ST_PDOWN;
			ST_PDOWN: begin
				if (levelSeen && !conf0_reg[B_LDD])
					state_next = ST_UNSYNC;
				else if (cmdTake && ciCmd == CMD_TIM)
					state_next = ST_PUP;
			end
			ST_PUP: begin
				if (levelSeen)
					state_next = ST_UNSYNC;
				else if (cmdTake && ciCmd == CMD_DI)
					state_next = ST_PDOWN;
				else if (cmdTake && (ciCmd == CMD_AR8 || ciCmd == CMD_AR10))
					state_next = ST_PEND_ACT;
			end
			ST_PEND_ACT: begin
				if (rxInfo == RX_I2)
					state_next = ST_SYNC;
				else if (rxInfo == RX_I4)
					state_next = ST_ACTIVE;
				else if (rxInfo == RX_IX)
					state_next = ST_UNSYNC;
				else if (cmdTake && ciCmd == CMD_DI)
					state_next = ST_PDOWN;
			end
			ST_UNSYNC: begin
				if (rxSync && rxInfo == RX_I2)
					state_next = ST_SYNC;
				else if (rxSync && rxInfo == RX_I4)
					state_next = ST_ACTIVE;
				else if (rxInfo == RX_I0)
					state_next = ST_PUP;
			end
			ST_SYNC: begin
				if (rxInfo == RX_I0)
					state_next = ST_PUP;
				else if (!rxSync)
					state_next = ST_LOST;
				else if (rxInfo == RX_I4)
					state_next = ST_ACTIVE;
			end
			ST_ACTIVE, ST_LOST: begin
				if (rxInfo == RX_I0)
					state_next = ST_PEND_DEACT;
				else if (!rxSync)
					state_next = ST_LOST;
				else if (rxInfo == RX_I4)
					state_next = ST_ACTIVE;
				else if (rxInfo == RX_I2)
					state_next = ST_SYNC;
			end
			ST_LOOP_CL:
				if (rxSync)
					state_next = ST_LOOP_ACT;
			ST_LOOP_ACT, ST_TEST1, ST_TEST2:
				if (cmdTake && ciCmd == CMD_DI)
					state_next = ST_PDOWN;
			default:
				state_next = ST_RESET;
		endcase
		// Commands valid from any state, ARL from any state but the two loop states
		if (cmdTake) begin
			case (ciCmd)
				CMD_RES: state_next = ST_RESET;
				CMD_TM1: state_next = ST_TEST1;
				CMD_TM2: state_next = ST_TEST2;
				CMD_ARL:
					if (!loopOn)
						state_next = ST_LOOP_CL;
				default: ;
			endcase
		end
		if (trDis)
			state_next = ST_RESET;
		else if (swSel)
			state_next = state_reg;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prio10_reg <= 1'b0;
		else if (cmdTake && ciCmd == CMD_AR8)
			prio10_reg <= 1'b0;
		else if (cmdTake && ciCmd == CMD_AR10)
			prio10_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Indications
	// ----------------------------------------------------------------
	always_comb begin
		case (state_reg)
			ST_RESET: indNext = IND_RES;
			ST_PEND_DEACT: indNext = IND_DR;
			ST_PDOWN: indNext = IND_DC;
			ST_PUP, ST_PEND_ACT: indNext = IND_PU;
			ST_UNSYNC, ST_LOST: indNext = IND_RSY;
			ST_SYNC: indNext = IND_AR;
			ST_ACTIVE: indNext = prio10_reg ? IND_AI10 : IND_AI8;
			ST_LOOP_CL: indNext = IND_ARL;
			ST_LOOP_ACT: indNext = IND_AIL;
			ST_TEST1, ST_TEST2: indNext = IND_TM;
			default: indNext = IND_RES;
		endcase
		if (loopOn && !extLp && levelSeen)
			indNext = IND_RSY;
		if (violShow_reg)
			indNext = IND_CVR;
	end

	// Violation is shown for one whole frame; a new one wins over the clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			violArm_reg <= 1'b0;
			violShow_reg <= 1'b0;
		end else begin
			if (rxViolation && conf0_reg[B_VIOLEN])
				violArm_reg <= 1'b1;
			else if (fscTick)
				violArm_reg <= 1'b0;
			if (fscTick)
				violShow_reg <= violArm_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ciInd <= IND_RES;
		else if (fscTick)
			ciInd <= indNext;
	end

	// ----------------------------------------------------------------
	// Transmitter and loops
	// ----------------------------------------------------------------
	always_comb begin
		if (swSel) begin
			case (swCmd_reg[1:0])
				2'h1: txMode = TX_I1;
				2'h2: txMode = TX_I3;
				default: txMode = TX_I0;
			endcase
		end else begin
			case (state_reg)
				ST_PEND_ACT: txMode = TX_I1;
				ST_SYNC, ST_ACTIVE, ST_LOOP_CL, ST_LOOP_ACT: txMode = TX_I3;
				ST_TEST1: txMode = TX_T1;
				ST_TEST2: txMode = TX_T2;
				default: txMode = TX_I0;
			endcase
		end
		if (trDis)
			txMode = TX_I0;
	end

	stl_line_tx u_lineTx (
		.mclk(mclk),
		.rst_n(rst_n),
		.bitTick(bitTick),
		.txMode(txMode),
		.bufDisable(txDis_reg),
		.frameData(upstreamData),
		.txPos(txPos),
		.txNeg(txNeg),
		.loopTxData(loopTxData)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intLoopEn <= 1'b0;
			awakeDetEn <= 1'b1;
		end else begin
			intLoopEn <= !trDis && !extLp &&
				(swSel ? swCmd_reg[B_ALOOP] : loopOn);
			awakeDetEn <= !trDis && !(extLp &&
				(swSel ? swCmd_reg[B_ALOOP] : loopOn));
		end
	end

	// ----------------------------------------------------------------
	// Terminal bus clocks and power down
	// ----------------------------------------------------------------
	assign ldEvent = levelSeen && !levelPrev_reg && state_reg == ST_PDOWN;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_reg <= 1'b0;
			levelPrev_reg <= 1'b0;
			clkRun_reg <= 1'b1;
		end else begin
			levelPrev_reg <= levelSeen;
			if (state_reg != ST_PDOWN)
				wake_reg <= 1'b0;
			else if (!conf0_reg[B_LDD] && levelSeen)
				wake_reg <= 1'b1;
			else if (spu_reg && wrAcc && dataAddr_reg == OFS_BUSCR &&
				!hwdata[B_SPU])
				wake_reg <= 1'b1;
			// Clocks stop only once the confirmation has gone out
			clkRun_reg <= !(state_reg == ST_PDOWN && ciInd == IND_DC &&
				cfs_reg && !wake_reg);
		end
	end

	// Stopped clocks park data high, data clock low, bit clock high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dataClockOut <= 1'b0;
			bitClock <= 1'b1;
			frameSyncOut <= 1'b0;
			downstreamData <= 1'b1;
		end else if (!clkRun_reg) begin
			dataClockOut <= 1'b0;
			bitClock <= 1'b1;
			frameSyncOut <= 1'b0;
			downstreamData <= 1'b1;
		end else begin
			if (dclTick) begin
				dataClockOut <= !dataClockOut;
				if (!dataClockOut)
					bitClock <= !bitClock;
			end
			if (fscTick)
				frameSyncOut <= 1'b1;
			else if (dclTick)
				frameSyncOut <= 1'b0;
			downstreamData <= intLoopEn ? upstreamData : rxData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dataClockOe_n <= 1'b0;
			frameSyncOe_n <= 1'b0;
		end else begin
			dataClockOe_n <= trDis;
			frameSyncOe_n <= trDis;
		end
	end

	// ----------------------------------------------------------------
	// Receiver status and interrupt flags
	// ----------------------------------------------------------------
	assign rxChange = rxStat_reg != {levelSeen, rxSync, rxInfo};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rxStat_reg <= 4'h0;
		else
			rxStat_reg <= {levelSeen, rxSync, rxInfo};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_reg <= 2'h0;
			irq <= 1'b0;
		end else begin
			if (rxChange)
				irqStat_reg[B_IRQ_RXCHG] <= 1'b1;
			else if (rdRxStat)
				irqStat_reg[B_IRQ_RXCHG] <= 1'b0;
			if (ldEvent && conf0_reg[B_LDD])
				irqStat_reg[B_IRQ_LD] <= 1'b1;
			else if (wrAcc && dataAddr_reg == OFS_ISTAT && hwdata[B_IRQ_LD])
				irqStat_reg[B_IRQ_LD] <= 1'b0;
			irq <= |(irqStat_reg & ~irqMask_reg);
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	assign addrPh = hsel && hready && htrans[1];
	assign wrAcc = dataPh_reg && dataWr_reg;
	assign rdRxStat = addrPh && !hwrite && haddr[7:0] == OFS_RXSTAT;

	always_comb begin
		rdNext = 32'h0000_0000;
		if (haddr[31:8] == 24'h00_0000) begin
			case (haddr[7:0])
				OFS_CONF0: rdNext[4:0] = conf0_reg;
				OFS_CONF2: rdNext[B_TXDIS] = txDis_reg;
				OFS_MODE_CONFIG1: rdNext[B_CFS] = cfs_reg;
				OFS_SWCMD: rdNext[2:0] = swCmd_reg;
				OFS_RXSTAT: rdNext[3:0] = rxStat_reg;
				OFS_ISTAT: rdNext[1:0] = irqStat_reg;
				OFS_IMASK: rdNext[1:0] = irqMask_reg;
				OFS_BUSCR: rdNext[B_SPU] = spu_reg;
				OFS_IND: rdNext[3:0] = ciInd;
				default: rdNext = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dataPh_reg <= 1'b0;
			dataWr_reg <= 1'b0;
			dataAddr_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				dataPh_reg <= addrPh;
				dataWr_reg <= addrPh && hwrite;
				dataAddr_reg <= (haddr[31:8] == 24'h00_0000) ?
					haddr[7:0] : 8'hff;
				if (addrPh && !hwrite)
					hrdata <= rdNext;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conf0_reg <= CONF0_RST;
			txDis_reg <= TXDIS_RST;
			cfs_reg <= CFS_RST;
			swCmd_reg <= SWCMD_RST;
			irqMask_reg <= IMASK_RST;
			spu_reg <= 1'b0;
		end else if (wrAcc) begin
			case (dataAddr_reg)
				OFS_CONF0: conf0_reg <= hwdata[4:0];
				OFS_CONF2: txDis_reg <= hwdata[B_TXDIS];
				OFS_MODE_CONFIG1: cfs_reg <= hwdata[B_CFS];
				OFS_SWCMD: swCmd_reg <= hwdata[2:0];
				OFS_IMASK: irqMask_reg <= hwdata[1:0];
				OFS_BUSCR: spu_reg <= hwdata[B_SPU];
				default: ;
			endcase
		end
	end
endmodule // stl_layer1_ctrl

// file: stl_line_tx.sv
// Upstream info and test pattern generator with AMI pulse coding
`timescale 1ns/1ps
module stl_line_tx
	import stl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic bitTick,
	input wire stl_tx_e txMode,
	input wire logic bufDisable,
	input wire logic frameData,
	output logic txPos,
	output logic txNeg,
	output logic loopTxData
);
	logic [5:0] bitCnt_reg;
	logic [2:0] patCnt_reg;
	logic polarity_reg;
	logic pulse;

	// Binary zero is sent as a mark of alternating polarity
	always_comb begin
		case (txMode)
			TX_I1: pulse = !INFO1_PAT[3'd7 - patCnt_reg];
			TX_I3: pulse = (bitCnt_reg == 6'h00) || !frameData;
			TX_T1: pulse = (bitCnt_reg == 6'h00);
			TX_T2: pulse = 1'b1;
			default: pulse = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_reg <= 6'h00;
			patCnt_reg <= 3'h0;
		end else if (bitTick) begin
			bitCnt_reg <= (bitCnt_reg == BITS_PER_FRAME - 6'h01) ?
				6'h00 : bitCnt_reg + 6'h01;
			patCnt_reg <= (txMode == TX_I1) ? patCnt_reg + 3'h1 : 3'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			polarity_reg <= 1'b0;
			txPos <= 1'b0;
			txNeg <= 1'b0;
			loopTxData <= 1'b1;
		end else if (bitTick) begin
			if (pulse)
				polarity_reg <= !polarity_reg;
			txPos <= pulse && !polarity_reg && !bufDisable;
			txNeg <= pulse && polarity_reg && !bufDisable;
			loopTxData <= !pulse;
		end
	end
endmodule // stl_line_tx

// file: stl_nt_model.sv
// Network-termination stand-in driving the receive side
`timescale 1ns/1ps
module stl_nt_model
	import stl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic txPos,
	input wire logic txNeg,
	input wire logic [1:0] sendInfo,
	output logic [1:0] rxInfo,
	output logic rxSync,
	output logic rxLevel,
	output logic rxViolation,
	output logic rxData
);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxInfo <= RX_I0;
			rxSync <= 1'b0;
			rxLevel <= 1'b0;
			rxViolation <= 1'b0;
			rxData <= 1'b1;
		end else begin
			rxInfo <= sendInfo;
			rxSync <= sendInfo[1];
			rxLevel <= sendInfo != RX_I0;
			rxViolation <= 1'b0;
			// Idle line toggles so no stale bit is seen
			rxData <= rxLevel ? ~(txPos | txNeg) : ~rxData;
		end
	end
endmodule // stl_nt_model

// file: stl_pkg.sv
// Constants, codes and register map of the layer-1 activation control
package stl_pkg;

	// ----------------------------------------------------------------
	// Clocking and rates
	// ----------------------------------------------------------------
	localparam longint CLK_HZ = 100_000_000;
	localparam longint BIT_HZ = 192_000;
	localparam longint DCL_EDGE_HZ = 3_072_000;
	localparam longint FSC_HZ = 8_000;
	localparam logic [31:0] BIT_INC = 32'((BIT_HZ << 32) / CLK_HZ);
	localparam logic [31:0] DCL_INC = 32'((DCL_EDGE_HZ << 32) / CLK_HZ);
	localparam logic [31:0] FSC_INC = 32'((FSC_HZ << 32) / CLK_HZ);
	localparam logic [5:0] BITS_PER_FRAME = 6'h30;
	localparam logic [7:0] INFO1_PAT = 8'h3f;

	// ----------------------------------------------------------------
	// Line infos and transmit modes
	// ----------------------------------------------------------------
	localparam logic [1:0] RX_I0 = 2'h0;
	localparam logic [1:0] RX_IX = 2'h1;
	localparam logic [1:0] RX_I2 = 2'h2;
	localparam logic [1:0] RX_I4 = 2'h3;
	typedef enum logic [2:0] {
		TX_I0 = 3'b000,
		TX_I1 = 3'b001,
		TX_I3 = 3'b010,
		TX_T1 = 3'b011,
		TX_T2 = 3'b100
	} stl_tx_e;

	// ----------------------------------------------------------------
	// Command and indication codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_TIM = 4'h0;
	localparam logic [3:0] CMD_RES = 4'h1;
	localparam logic [3:0] CMD_TM1 = 4'h2;
	localparam logic [3:0] CMD_TM2 = 4'h3;
	localparam logic [3:0] CMD_AR8 = 4'h8;
	localparam logic [3:0] CMD_AR10 = 4'h9;
	localparam logic [3:0] CMD_ARL = 4'ha;
	localparam logic [3:0] CMD_DI = 4'hf;
	localparam logic [3:0] IND_DR = 4'h0;
	localparam logic [3:0] IND_RES = 4'h1;
	localparam logic [3:0] IND_TM = 4'h2;
	localparam logic [3:0] IND_RSY = 4'h4;
	localparam logic [3:0] IND_PU = 4'h7;
	localparam logic [3:0] IND_AR = 4'h8;
	localparam logic [3:0] IND_ARL = 4'ha;
	localparam logic [3:0] IND_CVR = 4'hb;
	localparam logic [3:0] IND_AI8 = 4'hc;
	localparam logic [3:0] IND_AI10 = 4'hd;
	localparam logic [3:0] IND_AIL = 4'he;
	localparam logic [3:0] IND_DC = 4'hf;

	typedef enum logic [3:0] {
		ST_RESET = 4'b0000,
		ST_PEND_DEACT = 4'b0001,
		ST_PDOWN = 4'b0010,
		ST_PUP = 4'b0011,
		ST_PEND_ACT = 4'b0100,
		ST_UNSYNC = 4'b0101,
		ST_SYNC = 4'b0110,
		ST_ACTIVE = 4'b0111,
		ST_LOST = 4'b1000,
		ST_LOOP_CL = 4'b1001,
		ST_LOOP_ACT = 4'b1010,
		ST_TEST1 = 4'b1011,
		ST_TEST2 = 4'b1100
	} stl_state_e;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONF0 = 8'h00;
	localparam logic [7:0] OFS_CONF2 = 8'h04;
	localparam logic [7:0] OFS_MODE_CONFIG1 = 8'h08;
	localparam logic [7:0] OFS_SWCMD = 8'h0c;
	localparam logic [7:0] OFS_RXSTAT = 8'h10;
	localparam logic [7:0] OFS_ISTAT = 8'h14;
	localparam logic [7:0] OFS_IMASK = 8'h18;
	localparam logic [7:0] OFS_BUSCR = 8'h1c;
	localparam logic [7:0] OFS_IND = 8'h20;
	localparam int B_SWSEL = 0;
	localparam int B_VIOLEN = 1;
	localparam int B_LDD = 2;
	localparam int B_TRDIS = 3;
	localparam int B_EXTLP = 4;
	localparam int B_TXDIS = 0;
	localparam int B_CFS = 0;
	localparam int B_ALOOP = 2;
	localparam int B_SPU = 0;
	localparam int B_IRQ_RXCHG = 0;
	localparam int B_IRQ_LD = 1;
	localparam logic [4:0] CONF0_RST = 5'h00;
	localparam logic TXDIS_RST = 1'b1;
	localparam logic CFS_RST = 1'b0;
	localparam logic [2:0] SWCMD_RST = 3'h0;
	localparam logic [1:0] IMASK_RST = 2'h0;

endpackage

// file: stl_rate_gen.sv
// Phase accumulator giving a one-cycle enable at a fractional rate
`timescale 1ns/1ps
module stl_rate_gen #(
	parameter logic [31:0] INC = 32'h0000_0001
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	logic [32:0] accSum;
	logic [31:0] acc_reg;

	assign accSum = {1'b0, acc_reg} + {1'b0, INC};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (run) begin
			acc_reg <= accSum[31:0];
			tick <= accSum[32];
		end else begin
			acc_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end
	end
endmodule // stl_rate_gen

// file: testbench.sv
// Self-checking bench for the layer-1 activation control
`timescale 1ns/1ps
module testbench
	import stl_pkg::*;
;
	logic mclk = 0, rst_n = 0, hsel = 1, hwrite = 0, upstreamData = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, sendInfo = 0, rxInfo;
	logic [2:0] hsize = 3'h2;
	logic [3:0] ciCmd = 4'h1, ciInd;
	logic hreadyout, hresp, rxSync, rxLevel, rxViolation, rxData;
	logic downstreamData, dataClockOut, dataClockOe_n, frameSyncOut;
	logic frameSyncOe_n, bitClock, txPos, txNeg, loopTxData;
	logic intLoopEn, awakeDetEn, irq;
	int nErrors = 0, numChecks = 0;
	logic [9:0] marks = 0, pos = 0;
	logic [39:0] rows [10] = '{{OFS_CONF0, 32'h0}, {OFS_CONF2, 32'h1},
		{OFS_MODE_CONFIG1, 32'h0}, {OFS_SWCMD, 32'h0}, {OFS_IMASK, 32'h0},
		{OFS_BUSCR, 32'h0}, {OFS_IND, 32'h1}, {OFS_RXSTAT, 32'h0},
		{OFS_ISTAT, 32'h0}, {8'h40, 32'h0}};

	always #5 mclk = ~mclk;

	stl_layer1_ctrl uut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ciCmd, .ciInd, .rxInfo, .rxSync, .rxLevel, .rxViolation, .rxData,
		.upstreamData, .downstreamData, .dataClockOut, .dataClockOe_n,
		.frameSyncOut, .frameSyncOe_n, .bitClock, .txPos, .txNeg,
		.loopTxData, .intLoopEn, .awakeDetEn, .irq);
	stl_nt_model nt (.mclk, .rst_n, .txPos, .txNeg, .sendInfo, .rxInfo,
		.rxSync, .rxLevel, .rxViolation, .rxData);

	task automatic chk(input string nm, input logic [31:0] s, e);
		numChecks++;
		if (s !== e) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wait_ind(input logic [3:0] code);
		int i;
		for (i = 0; i < 40000 && ciInd !== code; i++)
			@(negedge mclk);
		chk("ciInd", {28'h0, ciInd}, {28'h0, code});
		@(posedge mclk);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (99000) @(posedge mclk);
		nErrors++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge mclk);
		chk("rstInd", {28'h0, ciInd}, 32'h1);
		chk("rstOe", {31'h0, dataClockOe_n}, 32'h0);
		rst_n <= 1'b1;
		@(posedge mclk);
		foreach (rows[i]) begin
			bus(1'b0, rows[i][39:32], 32'h0, rd);
			chk("regReset", rd, rows[i][31:0]);
		end
		chk("txQuiet", {30'h0, txPos, txNeg}, 32'h0);
		$display("test reset values done");
		bus(1'b1, OFS_CONF0, 32'h8, rd);
		repeat (3) @(posedge mclk);
		chk("oeOff", {30'h0, dataClockOe_n, frameSyncOe_n}, 32'h3);
		bus(1'b1, OFS_CONF0, 32'h0, rd);
		repeat (3) @(posedge mclk);
		chk("oeOn", {30'h0, dataClockOe_n, frameSyncOe_n}, 32'h0);
		$display("test transceiver disable done");
		sendInfo <= RX_IX;
		repeat (6) @(posedge mclk);
		chk("irqUp", {31'h0, irq}, 32'h1);
		bus(1'b0, OFS_RXSTAT, 32'h0, rd);
		chk("rxStat", rd, 32'h9);
		bus(1'b0, OFS_ISTAT, 32'h0, rd);
		chk("irqClr", rd, 32'h0);
		bus(1'b1, OFS_IMASK, 32'h1, rd);
		sendInfo <= RX_I0;
		repeat (6) @(posedge mclk);
		chk("irqMask", {31'h0, irq}, 32'h0);
		bus(1'b0, OFS_ISTAT, 32'h0, rd);
		chk("flagSet", rd, 32'h1);
		bus(1'b0, OFS_RXSTAT, 32'h0, rd);
		bus(1'b1, OFS_IMASK, 32'h0, rd);
		$display("test status change done");
		bus(1'b1, OFS_MODE_CONFIG1, 32'h1, rd);
		bus(1'b1, OFS_CONF0, 32'h4, rd);
		ciCmd <= CMD_DI;
		wait_ind(IND_DC);
		repeat (3) @(posedge mclk);
		chk("stopClk", {30'h0, dataClockOut, bitClock}, 32'h1);
		chk("stopData", {31'h0, downstreamData}, 32'h1);
		sendInfo <= RX_IX;
		repeat (4) @(posedge mclk);
		bus(1'b0, OFS_ISTAT, 32'h0, rd);
		chk("ldFlag", rd, 32'h3);
		sendInfo <= RX_I0;
		repeat (4) @(posedge mclk);
		bus(1'b1, OFS_ISTAT, 32'h2, rd);
		bus(1'b0, OFS_RXSTAT, 32'h0, rd);
		bus(1'b0, OFS_ISTAT, 32'h0, rd);
		chk("ldClr", rd, 32'h0);
		$display("test power down done");
		bus(1'b1, OFS_BUSCR, 32'h1, rd);
		bus(1'b1, OFS_BUSCR, 32'h0, rd);
		ciCmd <= CMD_TIM;
		wait_ind(IND_PU);
		sendInfo <= RX_IX;
		wait_ind(IND_RSY);
		sendInfo <= RX_I4;
		wait_ind(IND_AI8);
		sendInfo <= RX_I0;
		wait_ind(IND_DR);
		$display("test activation codes done");
		bus(1'b1, OFS_CONF0, 32'h1, rd);
		bus(1'b1, OFS_CONF2, 32'h0, rd);
		bus(1'b1, OFS_SWCMD, 32'h1, rd);
		// Sample each transmitted bit just after the bit enable acts
		for (int i = 0; i < 10; i++) begin
			do @(negedge mclk); while (uut.bitTick !== 1'b1);
			@(negedge mclk);
			marks = {marks[8:0], txPos | txNeg};
			pos = {pos[8:0], txPos};
		end
		@(posedge mclk);
		chk("info1", {22'h0, marks}, 32'h303);
		chk("amiAlt", {31'h0, pos[9] ^ pos[8]}, 32'h1);
		sendInfo <= RX_IX;
		bus(1'b1, OFS_SWCMD, 32'h0, rd);
		repeat (1100) @(posedge mclk);
		chk("info0", {30'h0, txPos, txNeg}, 32'h0);
		sendInfo <= RX_I4;
		repeat (4) @(posedge mclk);
		bus(1'b0, OFS_RXSTAT, 32'h0, rd);
		chk("swStat", rd, 32'hf);
		bus(1'b1, OFS_SWCMD, 32'h2, rd);
		bus(1'b1, OFS_SWCMD, 32'h4, rd);
		upstreamData <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("intLoop", {30'h0, intLoopEn, awakeDetEn}, 32'h3);
		chk("loopData", {31'h0, downstreamData}, 32'h0);
		bus(1'b1, OFS_CONF0, 32'h11, rd);
		repeat (3) @(posedge mclk);
		chk("extLoop", {30'h0, intLoopEn, awakeDetEn}, 32'h0);
		$display("test software control done");
		tally_and_finish();
	end
endmodule // testbench
